// >>> src/coc_pkg.sv
// package with register map, field layout, reset values and types of the csi-2 output control
//
// Function
// (RULE1) power-down pin low forces pins high impedance
// (RULE2) sleep select 0 forces outputs to HS-0
// (RULE3) sleep select 1, drive enable 0: high impedance
// (RULE4) both 1: valid only while inputs active
// (RULE5) input active exactly when receiver reports lock
// (RULE6) tx lock is OR over mapped ports
// (RULE7) software keeps transmitter on, changes forwarding only
// (RULE8) software disables forwarding around transmitter enable changes
// (RULE9) disable: forwarding, calibration, continuous clock, enable
// (RULE10) 0x28 to 0x21 selects synchronous line interleaving
// (RULE11) 0x00 to 0x20 forwards all four ports
// (RULE12) enable: transmit enable, calibration, then forwarding
// (RULE13) pin state re-evaluated each cycle, fixed priority
`default_nettype none
package coc_pkg;
   // register offsets
   localparam logic [7:0] COC_OFS_GEN_CFG   = 8'h02;
   localparam logic [7:0] COC_OFS_STATUS    = 8'h10;
   localparam logic [7:0] COC_OFS_FWD_MAP   = 8'h20;
   localparam logic [7:0] COC_OFS_FWD_MODE  = 8'h21;
   localparam logic [7:0] COC_OFS_TX_CTL    = 8'h33;
   localparam logic [7:0] COC_OFS_TX_CTL2   = 8'h34;
   // field positions
   localparam int COC_BIT_DRIVE_EN    = 0;
   localparam int COC_BIT_SLEEP_SEL   = 1;
   localparam int COC_BIT_TX_EN       = 0;
   localparam int COC_BIT_CONT_CLK    = 1;
   localparam int COC_BIT_PER_CAL     = 0;
   localparam int COC_STS_PIN_LSB     = 4;
   // reset values
   localparam logic [7:0] COC_RST_GEN_CFG  = 8'h03;
   localparam logic [7:0] COC_RST_FWD_MAP  = 8'h0F;
   localparam logic [7:0] COC_RST_FWD_MODE = 8'h00;
   localparam logic [7:0] COC_RST_TX_CTL   = 8'h00;
   localparam logic [7:0] COC_RST_TX_CTL2  = 8'h00;
   // forwarding codes
   localparam logic [7:0] COC_FWD_SYNC_LINE = 8'h28;
   localparam logic [7:0] COC_FWD_ALL_PORTS = 8'h00;
   // stream sizes
   localparam int COC_PORTS      = 4;
   localparam int COC_FIFO_DEPTH = 32;
   localparam int COC_WORD_W     = 10;

   typedef enum logic [1:0] {
      COC_PIN_HIZ,
      COC_PIN_HS0,
      COC_PIN_VALID
   } coc_pin_t;

   typedef struct packed {
      logic [1:0] port;
      logic [7:0] data;
   } coc_word_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } coc_reg_req_t;
endpackage : coc_pkg
`default_nettype wire

// >>> src/coc_output_ctl.sv
// csi-2 transmitter output control with receive sampling and stream fifo
`timescale 1ns/1ns
`default_nettype none

module coc_fifo #(
   parameter int W = 10,
   parameter int D = 32
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0]   count;
   } coc_fifo_st_t;

   coc_fifo_st_t st_q;
   coc_fifo_st_t st_d;
   logic [W-1:0] mem [D];
   logic         push;
   logic         pop;

   assign in_ready_o  = (st_q.count != (AW+1)'(D));
   assign out_valid_o = (st_q.count != '0);
   assign out_data_o  = mem[st_q.rptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wptr = (st_q.wptr == AW'(D-1)) ? '0 : st_q.wptr + 1'b1;
      end
      if (pop) begin
         st_d.rptr = (st_q.rptr == AW'(D-1)) ? '0 : st_q.rptr + 1'b1;
      end
      st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[st_q.wptr] <= in_data_i;
      end
   end
endmodule : coc_fifo

module coc_output_ctl
   import coc_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  power_down_pin_i,
   input  wire logic [COC_PORTS-1:0]  rx_lock_i,
   input  wire logic                  rx_link_clk_i,
   input  wire logic [1:0]            rx_port_i,
   input  wire logic [7:0]            rx_data_i,
   output logic                       rx_ready_o,
   input  wire logic                  reg_we_i,
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   output logic [7:0]                 reg_rdata_o,
   output logic                       csi_oe_o,
   output logic                       csi_hs0_o,
   output logic                       csi_valid_o,
   input  wire logic                  csi_ready_i,
   output logic [COC_WORD_W-1:0]      csi_data_o,
   output logic                       csi_sync_line_o,
   output logic                       csi_cont_clk_o,
   output logic                       csi_per_cal_o
);
   typedef struct packed {
      logic                  pdb_m;
      logic                  pdb_s;
      logic [COC_PORTS-1:0]  lock_m;
      logic [COC_PORTS-1:0]  lock_s;
      logic                  lclk_m;
      logic                  lclk_s;
      logic                  lclk_p;
      coc_word_t             word_m;
      coc_word_t             word_s;
      logic [7:0]            gen_cfg;
      logic [7:0]            fwd_map;
      logic [7:0]            fwd_mode;
      logic [7:0]            tx_ctl;
      logic [7:0]            tx_ctl2;
      coc_pin_t              pin;
      logic [7:0]            rdata;
      logic                  out_valid;
      logic [COC_WORD_W-1:0] out_data;
   } coc_st_t;

   coc_st_t                st_q;
   coc_st_t                st_d;
   coc_pin_t               pin_nx;
   coc_reg_req_t           req;
   logic [COC_PORTS-1:0]   port_en;
   logic                   tx_lock;
   logic                   tx_en;
   logic                   link_rise;
   logic                   push_valid;
   logic                   push_ready;
   logic                   pop_valid;
   logic                   pop_ready;
   logic [COC_WORD_W-1:0]  pop_data;

   assign req       = '{we: reg_we_i, addr: reg_addr_i, wdata: reg_wdata_i};
   // a clear bit forwards its port, so all-zero forwards every port
   assign port_en   = ~st_q.fwd_map[COC_PORTS-1:0];                       // RULE11
   assign tx_lock   = |(st_q.lock_s & port_en);                           // RULE5 RULE6
   assign tx_en     = st_q.tx_ctl[COC_BIT_TX_EN];
   assign link_rise = st_q.lclk_s && !st_q.lclk_p;
   // words from unmapped ports never enter the stream
   assign push_valid = link_rise && tx_en && port_en[st_q.word_s.port]
                       && st_q.lock_s[st_q.word_s.port];
   // refill only while the pins carry traffic and go on doing so, so the fifo keeps its words
   assign pop_ready  = (st_q.pin == COC_PIN_VALID) && (pin_nx == COC_PIN_VALID) && tx_en
                       && (!st_q.out_valid || csi_ready_i);

   // fixed priority: power-down, sleep select, drive enable, activity
   always_comb begin
      if (!st_q.pdb_s) begin
         pin_nx = COC_PIN_HIZ;                                             // RULE1 RULE13
      end else if (!st_q.gen_cfg[COC_BIT_SLEEP_SEL]) begin
         pin_nx = COC_PIN_HS0;                                             // RULE2
      end else if (!st_q.gen_cfg[COC_BIT_DRIVE_EN]) begin
         pin_nx = COC_PIN_HIZ;                                             // RULE3
      end else if (tx_lock) begin
         pin_nx = COC_PIN_VALID;                                           // RULE4
      end else begin
         pin_nx = COC_PIN_HIZ;                                             // RULE4
      end
   end

   coc_fifo #(
      .W (COC_WORD_W),
      .D (COC_FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (push_valid),
      .in_ready_o  (push_ready),
      .in_data_i   (st_q.word_s),
      .out_valid_o (pop_valid),
      .out_ready_i (pop_ready),
      .out_data_o  (pop_data)
   );

   always_comb begin
      st_d        = st_q;
      st_d.pdb_m  = power_down_pin_i;
      st_d.pdb_s  = st_q.pdb_m;
      st_d.lock_m = rx_lock_i;
      st_d.lock_s = st_q.lock_m;
      st_d.lclk_m = rx_link_clk_i;
      st_d.lclk_s = st_q.lclk_m;
      st_d.lclk_p = st_q.lclk_s;
      st_d.word_m = '{port: rx_port_i, data: rx_data_i};
      st_d.word_s = st_q.word_m;
      st_d.pin    = pin_nx;                                                // RULE13

      if (req.we) begin
         unique case (req.addr)
            COC_OFS_GEN_CFG:  st_d.gen_cfg  = req.wdata;
            COC_OFS_FWD_MAP:  st_d.fwd_map  = req.wdata;                   // RULE11
            COC_OFS_FWD_MODE: st_d.fwd_mode = req.wdata;                   // RULE10
            COC_OFS_TX_CTL:   st_d.tx_ctl   = req.wdata;
            COC_OFS_TX_CTL2:  st_d.tx_ctl2  = req.wdata;
            default: ;
         endcase
      end

      unique case (req.addr)
         COC_OFS_GEN_CFG:  st_d.rdata = st_q.gen_cfg;
         COC_OFS_STATUS:   st_d.rdata = {2'b00, st_q.pin, st_q.lock_s};
         COC_OFS_FWD_MAP:  st_d.rdata = st_q.fwd_map;
         COC_OFS_FWD_MODE: st_d.rdata = st_q.fwd_mode;
         COC_OFS_TX_CTL:   st_d.rdata = st_q.tx_ctl;
         COC_OFS_TX_CTL2:  st_d.rdata = st_q.tx_ctl2;
         default:          st_d.rdata = 8'h00;
      endcase

      // the staged word falls with the pin state, so no word outlives lock
      if (pin_nx != COC_PIN_VALID || !tx_en) begin                         // RULE4
         st_d.out_valid = 1'b0;
      end else if (pop_ready) begin
         st_d.out_valid = pop_valid;
         if (pop_valid) begin
            st_d.out_data = pop_data;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_q          <= '0;
         st_q.gen_cfg  <= COC_RST_GEN_CFG;
         st_q.fwd_map  <= COC_RST_FWD_MAP;
         st_q.fwd_mode <= COC_RST_FWD_MODE;
         st_q.tx_ctl   <= COC_RST_TX_CTL;
         st_q.tx_ctl2  <= COC_RST_TX_CTL2;
         st_q.pin      <= COC_PIN_HIZ;
      end else begin
         st_q <= st_d;
      end
   end

   assign rx_ready_o      = push_ready;
   assign reg_rdata_o     = st_q.rdata;
   assign csi_oe_o        = (st_q.pin != COC_PIN_HIZ);
   assign csi_hs0_o       = (st_q.pin == COC_PIN_HS0);
   assign csi_valid_o     = st_q.out_valid;
   assign csi_data_o      = st_q.out_data;
   assign csi_sync_line_o = (st_q.fwd_mode == COC_FWD_SYNC_LINE);          // RULE10
   assign csi_cont_clk_o  = st_q.tx_ctl[COC_BIT_CONT_CLK];
   assign csi_per_cal_o   = st_q.tx_ctl2[COC_BIT_PER_CAL];

   // pins and configuration held steady for four cycles
   sequence s_lock0_held;
      (power_down_pin_i && rx_lock_i[0] && port_en[0]
       && st_q.gen_cfg[COC_BIT_SLEEP_SEL] && st_q.gen_cfg[COC_BIT_DRIVE_EN])[*4];
   endsequence

   sequence s_pdb_low_held;
      (!power_down_pin_i)[*3];
   endsequence

   property p_pdb_hiz;
      @(posedge clk_i) disable iff (sys_rst_i)
      s_pdb_low_held |=> !csi_oe_o && !csi_hs0_o;
   endproperty
   a_pdb_hiz: assert property (p_pdb_hiz) else $error("pins driven in power-down"); // RULE1

   property p_hs0;
      @(posedge clk_i) disable iff (sys_rst_i)
      st_q.pdb_s && !st_q.gen_cfg[COC_BIT_SLEEP_SEL] |=> csi_hs0_o && csi_oe_o;
   endproperty
   a_hs0: assert property (p_hs0) else $error("sleep select 0 not in HS-0"); // RULE2

   property p_oen_hiz;
      @(posedge clk_i) disable iff (sys_rst_i)
      st_q.pdb_s && st_q.gen_cfg[COC_BIT_SLEEP_SEL] && !st_q.gen_cfg[COC_BIT_DRIVE_EN]
      |=> !csi_oe_o;
   endproperty
   a_oen_hiz: assert property (p_oen_hiz) else $error("drive enable 0 not hi-z"); // RULE3

   property p_inactive_hiz;
      @(posedge clk_i) disable iff (sys_rst_i)
      st_q.pdb_s && (st_q.gen_cfg[1:0] == 2'b11) && !(|(st_q.lock_s & port_en))
      |=> !csi_oe_o ##0 !csi_valid_o;
   endproperty
   a_inactive_hiz: assert property (p_inactive_hiz) else $error("inactive inputs drove pins"); // RULE4

   property p_lock_valid;
      @(posedge clk_i) disable iff (sys_rst_i)
      s_lock0_held |-> st_q.pin == COC_PIN_VALID;
   endproperty
   a_lock_valid: assert property (p_lock_valid) else $error("locked port gave no valid state"); // RULE5

   property p_or_lock;
      @(posedge clk_i) disable iff (sys_rst_i)
      st_q.pin == COC_PIN_VALID |-> $past(|(st_q.lock_s & port_en));
   endproperty
   a_or_lock: assert property (p_or_lock) else $error("valid state without mapped lock"); // RULE6

   property p_sync_line;
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_we_i && reg_addr_i == COC_OFS_FWD_MODE && reg_wdata_i == COC_FWD_SYNC_LINE
      |=> csi_sync_line_o
      ##1 (reg_rdata_o == COC_FWD_SYNC_LINE || $past(reg_addr_i) != COC_OFS_FWD_MODE);
   endproperty
   a_sync_line: assert property (p_sync_line) else $error("sync line mode not selected"); // RULE10

   property p_fwd_all;
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_we_i && reg_addr_i == COC_OFS_FWD_MAP && reg_wdata_i == COC_FWD_ALL_PORTS
      |=> port_en == 4'hF;
   endproperty
   a_fwd_all: assert property (p_fwd_all) else $error("not all ports forwarded"); // RULE11

   property p_prio;
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(csi_valid_o) |-> $past(st_q.pin) == COC_PIN_VALID && $past(st_q.pdb_s, 2);
   endproperty
   a_prio: assert property (p_prio) else $error("traffic outside valid state"); // RULE13
endmodule : coc_output_ctl
`default_nettype wire

// >>> sim/coc_csi_sink.sv
// downstream csi-2 receiver model that accepts stream words
`timescale 1ns/1ns
`default_nettype none

module coc_csi_sink
   import coc_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  stall_i,
   input  wire logic                  slow_i,
   input  wire logic                  oe_i,
   input  wire logic                  valid_i,
   input  wire logic [COC_WORD_W-1:0] data_i,
   output logic                       ready_o
);
   logic                  tog_q;
   logic [COC_WORD_W-1:0] got[$];

   // slow mode takes every other cycle so a held word must stand
   assign ready_o = !stall_i && (!slow_i || tog_q);

   always @(posedge clk_i) begin
      tog_q <= sys_rst_i ? 1'b0 : !tog_q;
      // a word only counts while the pins are really driven
      if (!sys_rst_i && oe_i && valid_i && ready_o) begin
         got.push_back(data_i);
      end
   end
endmodule : coc_csi_sink
`default_nettype wire

// >>> sim/coc_output_ctl_test.sv
// self-checking bench for the csi-2 output control with a stream sink
`timescale 1ns/1ns
`default_nettype none

module coc_output_ctl_test;
   import coc_pkg::*;
   typedef struct packed {
      logic       power_down_pin;
      logic [7:0] cfg;
      logic [3:0] lock;
      logic [7:0] map;
      logic [1:0] pin;
   } coc_row_t;
   localparam coc_row_t ROWS [8] = '{
      '{1'b0, 8'h03, 4'hF, 8'h00, 2'h0},
      '{1'b1, 8'h00, 4'h0, 8'h00, 2'h1},
      '{1'b1, 8'h01, 4'hF, 8'h00, 2'h1},
      '{1'b1, 8'h02, 4'hF, 8'h00, 2'h0},
      '{1'b1, 8'h03, 4'h0, 8'h00, 2'h0},
      '{1'b1, 8'h03, 4'h1, 8'h00, 2'h2},
      '{1'b1, 8'h03, 4'h8, 8'h08, 2'h0},
      '{1'b1, 8'h03, 4'h8, 8'h07, 2'h2}};

   logic       clk = 1'b0;
   logic       rst, power_down_pin, lclk, frame_on, we, stall, slow, full_seen;
   logic [3:0] lock;
   logic [1:0] port;
   logic [7:0] data, addr, wdata, rdata;
   logic       rx_ready, oe, hs0, valid, ready, sync, cont, cal;
   logic [9:0] cdata;
   int         err_count = 0;
   int         n_checks = 0;

   always #4 clk = ~clk;

   // link clock stands low between frames
   initial begin
      lclk = 1'b0;
      #3;
      forever #80 lclk = frame_on ? ~lclk : 1'b0;
   end

   coc_output_ctl u_dut (.clk_i(clk), .sys_rst_i(rst), .power_down_pin_i(power_down_pin),
      .rx_lock_i(lock), .rx_link_clk_i(lclk), .rx_port_i(port), .rx_data_i(data),
      .rx_ready_o(rx_ready), .reg_we_i(we), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .csi_oe_o(oe), .csi_hs0_o(hs0), .csi_valid_o(valid),
      .csi_ready_i(ready), .csi_data_o(cdata), .csi_sync_line_o(sync),
      .csi_cont_clk_o(cont), .csi_per_cal_o(cal));

   coc_csi_sink u_sink (.clk_i(clk), .sys_rst_i(rst), .stall_i(stall), .slow_i(slow),
      .oe_i(oe), .valid_i(valid), .data_i(cdata), .ready_o(ready));

   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      we = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      we = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge clk);
      addr = a;
      repeat (2) @(negedge clk);
      check(what, {2'b00, rdata}, {2'b00, exp});
   endtask : rd

   // data changes early in the low phase, just after the fall, far from the sampled rise
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         port = i[1:0];
         data = i[7:0];
         if (rx_ready === 1'b0) full_seen = 1'b1;
         // first word settles before the clock starts, so no stale rise
         if (!frame_on) begin
            repeat (4) @(negedge clk);
            frame_on = 1'b1;
         end
         @(posedge lclk);
         @(negedge lclk);
      end
      frame_on = 1'b0;
   endtask : send

   initial begin
      rst = 1'b1; power_down_pin = 1'b0; lock = 4'h0; port = 2'h0; data = 8'h00; we = 1'b0;
      addr = 8'h00; wdata = 8'h00; frame_on = 1'b0; stall = 1'b0; slow = 1'b0;
      full_seen = 1'b0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check("reset outputs", {4'h0, oe, hs0, valid, sync, cont, cal}, 10'h0);
      check("reset ready", {9'h0, rx_ready}, 10'h1);
      rd(COC_OFS_GEN_CFG, COC_RST_GEN_CFG, "cfg reset");
      rd(COC_OFS_FWD_MAP, COC_RST_FWD_MAP, "map reset");
      rd(COC_OFS_FWD_MODE, COC_RST_FWD_MODE, "mode reset");
      rd(COC_OFS_TX_CTL, COC_RST_TX_CTL, "tx reset");
      rd(COC_OFS_TX_CTL2, COC_RST_TX_CTL2, "tx2 reset");
      foreach (ROWS[i]) begin
         power_down_pin = ROWS[i].power_down_pin;
         lock = ROWS[i].lock;
         wr(COC_OFS_GEN_CFG, ROWS[i].cfg);
         wr(COC_OFS_FWD_MAP, ROWS[i].map);
         repeat (4) @(negedge clk);
         check("pin state", {8'h00, oe, hs0}, {8'h00, ROWS[i].pin != 2'h0, ROWS[i].pin == 2'h1});
         rd(COC_OFS_STATUS, {2'b00, ROWS[i].pin, ROWS[i].lock}, "status");
      end
      power_down_pin = 1'b1;
      lock = 4'hF;
      wr(COC_OFS_GEN_CFG, 8'h03);
      // enable order: transmitter, calibration, then forwarding
      wr(COC_OFS_TX_CTL, 8'h03);
      wr(COC_OFS_TX_CTL2, 8'h01);
      wr(COC_OFS_FWD_MODE, COC_FWD_SYNC_LINE);
      wr(COC_OFS_FWD_MAP, COC_FWD_ALL_PORTS);
      repeat (3) @(negedge clk);
      check("tx controls", {7'h0, sync, cont, cal}, 10'h7);
      rd(COC_OFS_FWD_MODE, 8'h28, "mode");
      rd(COC_OFS_FWD_MAP, 8'h00, "map");
      wr(8'h55, 8'hA5);
      rd(8'h55, 8'h00, "unmapped");
      stall = 1'b1;
      send(40);
      check("fifo refused", {9'h0, full_seen}, 10'h1);
      stall = 1'b0;
      slow = 1'b1;
      for (int i = 0; i < 4000 && u_sink.got.size() < 32; i++) @(negedge clk);
      // a drain that runs out counts once and the run goes on to the verdict
      if (u_sink.got.size() < 32) begin
         err_count++;
      end
      for (int k = 0; k < 4; k++) check("word", u_sink.got[k], {k[1:0], k[7:0]});
      check("ready after drain", {9'h0, rx_ready}, 10'h1);
      lock = 4'h0;
      repeat (4) @(negedge clk);
      check("lock lost", {8'h0, oe, valid}, 10'h0);
      // disable order: forwarding, calibration, continuous clock, enable
      wr(COC_OFS_FWD_MAP, 8'h0F);
      wr(COC_OFS_TX_CTL2, 8'h00);
      wr(COC_OFS_TX_CTL, 8'h01);
      wr(COC_OFS_TX_CTL, 8'h00);
      repeat (3) @(negedge clk);
      check("tx off", {8'h0, cont, cal}, 10'h0);
      print_verdict();
   end
endmodule : coc_output_ctl_test
`default_nettype wire
